// *** hdl/lsc_cfg.svh ***
`ifndef LSC_CFG_SVH
`define LSC_CFG_SVH

// Register offsets on the serial register port.
`define LSC_OFS_CH3       8'h25
`define LSC_OFS_CH4       8'h26
`define LSC_OFS_CH5       8'h27
`define LSC_OFS_CH6       8'h28
`define LSC_OFS_CH7       8'h29
`define LSC_OFS_CH8       8'h2a
`define LSC_OFS_OPT       8'h2f

// Reset values.
`define LSC_RST_SINK      8'haf
`define LSC_RST_OPT       8'h40

// Option register field positions.
`define LSC_BIT_AUTOINC   6
`define LSC_BIT_PSAVE     5
`define LSC_BIT_GAIN_HI   4
`define LSC_BIT_GAIN_LO   3
`define LSC_BIT_UNITY     2
`define LSC_BIT_INTCLK    0
`define LSC_OPT_WMASK     8'h7d

// Sink current step in microamps per code.
`define LSC_STEP_UA       100

`endif

// *** hdl/lsc_pkg.sv ***
package lsc_pkg;

  typedef enum logic [1:0] {
    LSC_PUMP_OFF  = 2'b00,
    LSC_PUMP_X1   = 2'b01,
    LSC_PUMP_X1P5 = 2'b10,
    LSC_PUMP_AUTO = 2'b11
  } lsc_pump_type;

  // Register port request, one access per cycle.
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } lsc_req_type;

  // Decoded option register contents.
  typedef struct packed {
    logic         auto_incr;
    logic         power_save;
    lsc_pump_type pump_gain_sel;
    logic         pump_unity_on_sleep;
    logic         int_clk_sel;
  } lsc_opt_type;

endpackage

// *** hdl/lsc_sink_reg.sv ***
`timescale 1ns/1ps
`include "lsc_cfg.svh"

// One channel sink level register with its own current figure.
module lsc_sink_reg #(
  parameter int unsigned STEP_UA = `LSC_STEP_UA
) (
  input  wire logic        i_clk_sys,
  input  wire logic        i_arst_n,
  input  wire logic        i_we,
  input  wire logic [7:0]  i_wdata,
  output logic      [7:0]  o_code,
  output logic      [15:0] o_sink_ua
);
  import lsc_pkg::*;

  logic [7:0]  code_q;
  logic [7:0]  code_d;
  logic [15:0] ua_q;
  logic [15:0] ua_d;

  // The current figure is registered beside the code so that it leaves
  // on a flip-flop, at the cost of sixteen more flops per channel.
  always_comb begin
    code_d = code_q;
    if (i_we) begin
      code_d = i_wdata;
    end
    // Linear map, 00h gives zero and FFh gives the top current.
    ua_d = 16'(code_d * STEP_UA);
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      code_q <= `LSC_RST_SINK;
      ua_q   <= 16'(`LSC_RST_SINK * STEP_UA);
    end else begin
      code_q <= code_d;
      ua_q   <= ua_d;
    end
  end

  assign o_code    = code_q;
  assign o_sink_ua = ua_q;
endmodule // lsc_sink_reg

// *** hdl/lsc_regs.sv ***
`timescale 1ns/1ps
`include "lsc_cfg.svh"

module lsc_regs #(
  parameter int unsigned NUM_CH  = 6,
  parameter int unsigned STEP_UA = `LSC_STEP_UA
) (
  input  wire logic                 i_clk_sys,
  input  wire logic                 i_arst_n,
  input  wire lsc_pkg::lsc_req_type i_req,
  input  wire logic                 i_sleep_entry,
  output logic      [7:0]           o_rdata,
  output logic                      o_rvalid,
  output logic      [7:0]           o_next_addr,
  output logic      [NUM_CH*8-1:0]  o_sink_code,
  output logic      [NUM_CH*16-1:0] o_sink_ua,
  output lsc_pkg::lsc_opt_type      o_opt,
  output lsc_pkg::lsc_pump_type     o_pump_mode,
  output logic                      o_pump_pulldown,
  output logic                      o_int_osc_en
);
  import lsc_pkg::*;

  // ****************************************************************
  // Address decode
  // ****************************************************************

  // Channel 3 sits just below channel 4 so the six form one run.
  // The run is clipped to NUM_CH, so a narrower build never indexes
  // past its last channel register.
  function automatic logic is_sink(input logic [7:0] a);
    logic [7:0] d;
    d = a - `LSC_OFS_CH3;
    return (a >= `LSC_OFS_CH3) && (a <= `LSC_OFS_CH8) &&
           (32'(d) < NUM_CH);
  endfunction

  // Option register write, shared by the store and the pump latch.
  function automatic logic is_opt_wr(input lsc_req_type r);
    return r.wr && (r.addr == `LSC_OFS_OPT);
  endfunction

  // Pump gain field of an option byte.
  function automatic lsc_pump_type gain_of(input logic [7:0] v);
    return lsc_pump_type'(v[`LSC_BIT_GAIN_HI:`LSC_BIT_GAIN_LO]);
  endfunction

  function automatic logic [2:0] sink_idx(input logic [7:0] a);
    logic [7:0] d;
    d = a - `LSC_OFS_CH3;
    return d[2:0];
  endfunction

  logic [NUM_CH-1:0] sink_we;
  logic [7:0]        codes [NUM_CH];

  // Writes outside the mapped run fall through and change nothing.
  always_comb begin
    sink_we = '0;
    if (i_req.wr && is_sink(i_req.addr)) begin
      sink_we[sink_idx(i_req.addr)] = 1'b1;
    end
  end

  // ****************************************************************
  // Channel sink level registers
  // ****************************************************************

  // Each channel is its own instance, so a write strobe can reach only
  // the one register that its address decodes to.
  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
    lsc_sink_reg #(
      .STEP_UA (STEP_UA)
    ) u_sink (
      .i_clk_sys (i_clk_sys),
      .i_arst_n  (i_arst_n),
      .i_we      (sink_we[g]),
      .i_wdata   (i_req.wdata),
      .o_code    (codes[g]),
      .o_sink_ua (o_sink_ua[g*16 +: 16])
    );
    assign o_sink_code[g*8 +: 8] = codes[g];
  end

  // ****************************************************************
  // Option register
  // ****************************************************************

  // Bits 7 and 1 are masked on the way in rather than on read, which
  // keeps the stored byte and the read-back always equal.
  logic [7:0] opt_q;
  logic [7:0] opt_d;

  always_comb begin
    opt_d = opt_q;
    if (is_opt_wr(i_req)) begin
      // Reserved bits are not stored, so they always read zero.
      opt_d = i_req.wdata & `LSC_OPT_WMASK;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      opt_q <= `LSC_RST_OPT;
    end else begin
      opt_q <= opt_d;
    end
  end

  assign o_opt.auto_incr           = opt_q[`LSC_BIT_AUTOINC];
  assign o_opt.power_save          = opt_q[`LSC_BIT_PSAVE];
  assign o_opt.pump_gain_sel       = gain_of(opt_q);
  assign o_opt.pump_unity_on_sleep = opt_q[`LSC_BIT_UNITY];
  // Clock select is static; the host only moves it with chip enable low.
  assign o_opt.int_clk_sel         = opt_q[`LSC_BIT_INTCLK];

  // The oscillator enable follows the select bit directly; moving the
  // source while the chip runs is left to the host.
  assign o_int_osc_en = opt_q[`LSC_BIT_INTCLK];

  // ****************************************************************
  // Charge pump mode
  // ****************************************************************

  // Once forced to 1x the pump stays there until software rewrites
  // the option register, so a sleep entry cannot be silently undone.
  // The effective mode is registered from the next values, so it moves
  // on the same edge as the option register and never glitches at the
  // analog pump controls.
  logic         force_x1_q;
  logic         force_x1_d;
  lsc_pump_type pump_mode_q;
  lsc_pump_type pump_mode_d;
  logic         pulldown_q;
  logic         pulldown_d;

  always_comb begin
    force_x1_d = force_x1_q;
    if (is_opt_wr(i_req)) begin
      force_x1_d = 1'b0;
    end
    // A sleep entry in the same cycle as an option write still forces if the unity bit held before the write is set.
    if (i_sleep_entry && opt_q[`LSC_BIT_UNITY]) begin
      force_x1_d = 1'b1;
    end
    pump_mode_d = gain_of(opt_d);
    if (force_x1_d) begin
      pump_mode_d = LSC_PUMP_X1;
    end
    pulldown_d = (pump_mode_d == LSC_PUMP_OFF);
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      force_x1_q  <= 1'b0;
      pump_mode_q <= LSC_PUMP_OFF;
      pulldown_q  <= 1'b1;
    end else begin
      force_x1_q  <= force_x1_d;
      pump_mode_q <= pump_mode_d;
      pulldown_q  <= pulldown_d;
    end
  end

  assign o_pump_mode     = pump_mode_q;
  assign o_pump_pulldown = pulldown_q;

  // ****************************************************************
  // Read data and address advance
  // ****************************************************************

  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic       rvalid_q;
  logic       rvalid_d;
  logic [7:0] naddr_q;
  logic [7:0] naddr_d;

  // A read of a register written in the same cycle returns the old
  // value; the host sees the new one on its next access.
  // Read valid is a one-cycle pulse, while the data stands until the
  // next read.
  always_comb begin
    rdata_d  = rdata_q;
    rvalid_d = i_req.rd;
    naddr_d  = naddr_q;
    if (i_req.rd) begin
      rdata_d = 8'h00;
      if (is_sink(i_req.addr)) begin
        rdata_d = codes[sink_idx(i_req.addr)];
      end else if (i_req.addr == `LSC_OFS_OPT) begin
        rdata_d = opt_q;
      end
    end
    if (i_req.rd || i_req.wr) begin
      // With auto-increment off the serial pointer stays put.
      naddr_d = opt_q[`LSC_BIT_AUTOINC] ? i_req.addr + 8'h01
                                        : i_req.addr;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rdata_q  <= 8'h00;
      rvalid_q <= 1'b0;
      naddr_q  <= 8'h00;
    end else begin
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
      naddr_q  <= naddr_d;
    end
  end

  assign o_rdata     = rdata_q;
  assign o_rvalid    = rvalid_q;
  assign o_next_addr = naddr_q;
endmodule // lsc_regs

// *** verification/lsc_regs_props.sv ***
`timescale 1ns/1ps
// ****************************************
// Port checks of the register block.
// ****************************************
module lsc_regs_props #(
  parameter int unsigned NUM_CH = 6
) (
  input wire logic                  i_clk_sys,
  input wire logic                  i_arst_n,
  input wire lsc_pkg::lsc_req_type  i_req,
  input wire logic                  i_sleep_entry,
  input wire logic [7:0]            o_rdata,
  input wire logic                  o_rvalid,
  input wire logic [7:0]            o_next_addr,
  input wire logic [NUM_CH*8-1:0]   o_sink_code,
  input wire logic [NUM_CH*16-1:0]  o_sink_ua,
  input wire lsc_pkg::lsc_opt_type  o_opt,
  input wire lsc_pkg::lsc_pump_type o_pump_mode,
  input wire logic                  o_pump_pulldown,
  input wire logic                  o_int_osc_en
);
  import lsc_pkg::*;
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_arst_n);
  a_ua_linear: assert property (
    o_sink_ua[15:0] == 16'(o_sink_code[7:0]) * 16'h0064)
    else $error("sink current off its code");
  a_write_lands: assert property (
    i_req.wr && i_req.addr == 8'h2a
    |=> o_sink_code[47:40] == $past(i_req.wdata))
    else $error("write not stored");
  a_read_pulse: assert property (o_rvalid == $past(i_req.rd))
    else $error("read valid off");
  a_unmapped_zero: assert property (
    i_req.rd && i_req.addr == 8'h2b |=> o_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_addr_step: assert property (
    (i_req.wr || i_req.rd) && i_req.addr != 8'h2f && o_opt.auto_incr
    |=> o_next_addr == $past(i_req.addr) + 8'h01)
    else $error("pointer did not advance");
  a_addr_hold: assert property (
    (i_req.wr || i_req.rd) && i_req.addr != 8'h2f && !o_opt.auto_incr
    |=> o_next_addr == $past(i_req.addr))
    else $error("pointer moved");
  a_pull_down: assert property (
    o_pump_pulldown == (o_pump_mode == LSC_PUMP_OFF))
    else $error("pulldown off");
  a_unity_sleep: assert property (
    i_sleep_entry && o_opt.pump_unity_on_sleep |=> o_pump_mode == LSC_PUMP_X1)
    else $error("pump not forced");
  a_mode_kept: assert property (
    !o_opt.pump_unity_on_sleep |-> o_pump_mode == o_opt.pump_gain_sel)
    else $error("pump mode changed");
  a_osc_select: assert property (
    i_req.wr && i_req.addr == 8'h2f
    |=> o_int_osc_en == $past(i_req.wdata[0]))
    else $error("oscillator select not stored");
endmodule // lsc_regs_props

bind lsc_regs lsc_regs_props #(.NUM_CH(NUM_CH)) i_lsc_regs_props (
  .i_clk_sys, .i_arst_n, .i_req, .i_sleep_entry, .o_rdata, .o_rvalid,
  .o_next_addr, .o_sink_code, .o_sink_ua, .o_opt, .o_pump_mode,
  .o_pump_pulldown, .o_int_osc_en);

// *** verification/lsc_host.sv ***
`timescale 1ns/1ps
// ****************************************
// Host on the register port.
// ****************************************
module lsc_host (
  input  wire logic            i_clk_sys,
  output lsc_pkg::lsc_req_type o_req
);
  import lsc_pkg::*;
  // Chip enable sits outside this block and stays low in this run, so
  // the host may move the clock select; with it high the bit is held.
  logic chip_en = 1'b0;
  logic clk_sel = 1'b0;
  initial o_req = '0;
  task automatic acc(input logic w, input logic [7:0] a, d);
    logic [7:0] v;
    v = d;
    if (a == 8'h2f) begin
      v = d & 8'h7d;
      if (chip_en) begin
        v[0] = clk_sel;
      end
    end
    @(negedge i_clk_sys);
    o_req.wr = w;
    o_req.rd = !w;
    o_req.addr = a;
    o_req.wdata = v;
    if (w && a == 8'h2f) begin
      clk_sel = v[0];
    end
    @(negedge i_clk_sys);
    o_req = '0;
  endtask
endmodule // lsc_host

// *** verification/led_sink_current_and_misc_config_bench.sv ***
`timescale 1ns/1ps
// ****************************************
// Scenarios.
// ****************************************
module led_sink_current_and_misc_config_bench;
  import lsc_pkg::*;
  logic          i_clk_sys = 1'b0;
  logic          i_arst_n = 1'b0;
  logic          i_sleep_entry = 1'b0;
  lsc_req_type   i_req;
  logic [7:0]    o_rdata, o_next_addr;
  logic          o_rvalid, o_pump_pulldown, o_int_osc_en;
  logic [47:0]   o_sink_code;
  logic [95:0]   o_sink_ua;
  lsc_opt_type   o_opt;
  lsc_pump_type  o_pump_mode;
  int            n_mismatch = 0;
  int            comparisons = 0;
  lsc_regs i_lsc_regs (.i_clk_sys, .i_arst_n, .i_req, .i_sleep_entry,
    .o_rdata, .o_rvalid, .o_next_addr, .o_sink_code, .o_sink_ua, .o_opt,
    .o_pump_mode, .o_pump_pulldown, .o_int_osc_en);
  lsc_host i_lsc_host (.i_clk_sys, .o_req(i_req));
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    comparisons++;
    if (s !== e) begin
      n_mismatch++;
      $display("mismatch at %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    i_lsc_host.acc(1'b0, a, 8'h00);
    chk(o_rvalid, 1'b1);
    chk(o_rdata, e);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_lsc_host.acc(1'b1, a, d);
  endtask
  task automatic nap();
    @(negedge i_clk_sys);
    i_sleep_entry = 1'b1;
    @(negedge i_clk_sys);
    i_sleep_entry = 1'b0;
  endtask
  task automatic t_reset();
    for (int i = 0; i < 6; i++) begin
      rd(8'h25 + 8'(i), 8'haf);
      chk(o_sink_ua[i*16+:16], 16'h445c);
    end
    rd(8'h2f, 8'h40);
    chk(o_opt, 16'h0020);
    chk(o_pump_pulldown, 1'b1);
  endtask
  task automatic t_sink();
    logic [7:0] d;
    for (int i = 0; i < 6; i++)
      wr(8'h25 + 8'(i), 8'h33 * 8'(i));
    for (int i = 0; i < 6; i++) begin
      d = 8'h33 * 8'(i);
      chk(o_sink_code[i*8+:8], d);
      chk(o_sink_ua[i*16+:16], 16'(d) * 16'h0064);
      rd(8'h25 + 8'(i), d);
    end
    wr(8'h2b, 8'hff);
    rd(8'h2b, 8'h00);
  endtask
  task automatic t_incr();
    rd(8'h29, 8'hcc);
    chk(o_next_addr, 8'h2a);
    wr(8'h2f, 8'h00);
    rd(8'h28, 8'h99);
    chk(o_next_addr, 8'h28);
  endtask
  task automatic t_pump();
    for (int m = 0; m < 4; m++) begin
      wr(8'h2f, 8'h40 | 8'(m << 3));
      chk(o_pump_mode, 16'(m));
      chk(o_pump_pulldown, m == 0);
    end
    wr(8'h2f, 8'h75);
    rd(8'h2f, 8'h75);
    chk(o_int_osc_en, 1'b1);
    nap();
    chk(o_pump_mode, LSC_PUMP_X1);
    wr(8'h2f, 8'h70);
    nap();
    chk(o_pump_mode, LSC_PUMP_X1P5);
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    forever #20 i_clk_sys = ~i_clk_sys;
  end
  // The run needs about 70 cycles, so 2500 cycles means a hang.
  initial begin
    #100000;
    n_mismatch++;
    final_report();
  end
  initial begin
    repeat (2) @(posedge i_clk_sys);
    @(negedge i_clk_sys);
    i_arst_n = 1'b1;
    t_reset();
    t_sink();
    t_incr();
    t_pump();
    final_report();
  end
endmodule // led_sink_current_and_misc_config_bench
